// ==== logic/slt_consts.vh ====
/*
  slt_consts.vh: offsets, field positions, reset values and timing counts
  for the stn timing and fetch block.
  assumes: included by its bare name from files under logic/.
*/
`ifndef SLT_CONSTS_VH
`define SLT_CONSTS_VH

// register index map (byte address = offset, word aligned)
`define SLT_REG_CTRL      8'h00
`define SLT_REG_HTIME     8'h04
`define SLT_REG_VTIME     8'h08
`define SLT_REG_BIAS      8'h0c
`define SLT_REG_BASE      8'h10
`define SLT_REG_STATUS    8'h14
`define SLT_REG_FIFO      8'h18

// ctrl fields
`define SLT_CTRL_EN       0
`define SLT_CTRL_BSEL     1
`define SLT_CTRL_PT_LO    2
`define SLT_CTRL_PT_HI    3
`define SLT_CTRL_BIG      4
`define SLT_CTRL_DIV_LO   8
`define SLT_CTRL_DIV_HI   17

// panel types
`define SLT_PT_DUAL4      2'h0
`define SLT_PT_SINGLE4    2'h1
`define SLT_PT_SINGLE8    2'h2

// reset values
`define SLT_CTRL_RST      32'h0000_0208
`define SLT_HTIME_RST     32'h0000_004f
`define SLT_VTIME_RST     32'h0000_00ef
`define SLT_BIAS_RST      32'h0000_0002

// structural figures
`define SLT_DIV_MIN       10'h002
`define SLT_WLH_BASE      4
`define SLT_BLANK_MULT    8
`define SLT_BURST_WORDS   4
`define SLT_UPPER_DEPTH   16
`define SLT_LOWER_DEPTH   12

`endif

// ==== logic/slt_stn_timing.v ====
/*
  slt_stn_timing.v: stn panel timing generator with burst fetch dma
  and split upper/lower word fifos, register port for software.
  assumes: one bus clock ref_clk_i, synchronous active low reset, a
  memory port that grants a burst then returns four words with a valid.
*/
// Implementation choices: the register offsets and the plain strobed port.
// Function
// - frame pulse high for the whole first line of every frame.
// - bias select 0 inverts ac bias output once per frame.
// - bias select 1 inverts ac bias after each bias_line_count line pulses.
// - four data lines for single 4-bit panels, eight for dual 4-bit and 8-bit single scan.
// - pixel clock is bus clock over twice divisor; divisor clamped at two.
// - line lasts h+1 pixel clocks plus pulse, delay and blank bus clocks.
// - dma asks for four-word burst when fifo has room, holds bus till done.
// - 28 words of fifo, 12 lower plus 16 upper, both used for dual scan.
// - single scan fills only the upper fifo.
// - stn pixel formats mono, gray and colour; only mono shifting is built.
// - three panel organisations, dual 4-bit, single 4-bit, single 8-bit.
// - tft formats are outside this stn front end.
// - virtual screen up to 16 megabytes via 22-bit word address.
// - frame sync and fifo count events are offered as pulse outputs.
// - configuration registers live behind the register port.
// - little or big endian byte order of fetched words.
// - mono mode shifts upper (and lower) fifo data out in nibbles or bytes.
`include "slt_consts.vh"
`timescale 1ns/10ps
`default_nettype none

module slt_stn_timing (
  input  wire        ref_clk_i,
  input  wire        resetn_i,
  input  wire [7:0]  reg_addr_i,
  input  wire [31:0] reg_wdata_i,
  input  wire        reg_wr_i,
  input  wire        reg_rd_i,
  output reg  [31:0] reg_rdata_o,
  output wire        mem_req_o,
  output wire [21:0] mem_addr_o,
  input  wire        mem_gnt_i,
  input  wire        mem_valid_i,
  input  wire [31:0] mem_data_i,
  output reg         frame_pulse_o,
  output reg         line_pulse_o,
  output reg         pixel_clock_out_o,
  output reg         ac_bias_toggle_o,
  output reg  [7:0]  pixel_data_bus_o,
  output reg         frame_sync_irq_o,
  output reg         fifo_count_irq_o
);

  localparam ST_ACTIVE = 4'b0001;
  localparam ST_PULSE  = 4'b0010;
  localparam ST_DELAY  = 4'b0100;
  localparam ST_BLANK  = 4'b1000;

  reg [31:0] ctrl_q, htime_q, vtime_q, bias_q;
  reg [21:0] base_q;
  reg [3:0]  st_q;
  reg [9:0]  div_q;
  reg [10:0] hcnt_q;
  reg [9:0]  vcnt_q;
  reg [12:0] wcnt_q;
  reg [7:0]  bcnt_q;
  reg [21:0] fetch_q;
  reg        busy_q;
  reg [1:0]  beat_q;
  reg        side_q;
  reg [31:0] up_mem [0:`SLT_UPPER_DEPTH-1];
  reg [31:0] lo_mem [0:`SLT_LOWER_DEPTH-1];
  reg [4:0]  up_cnt_q, lo_cnt_q;
  reg [3:0]  up_wr_q, up_rd_q, lo_wr_q, lo_rd_q;
  reg [31:0] sh_q;
  reg [2:0]  sh_left_q;

  // config fields
  wire       en      = ctrl_q[`SLT_CTRL_EN];
  wire       bsel    = ctrl_q[`SLT_CTRL_BSEL];
  wire [1:0] ptype   = ctrl_q[`SLT_CTRL_PT_HI:`SLT_CTRL_PT_LO];
  wire       dual    = (ptype == `SLT_PT_DUAL4);
  wire       wide    = (ptype == `SLT_PT_SINGLE8);
  wire [9:0] div_raw = ctrl_q[`SLT_CTRL_DIV_HI:`SLT_CTRL_DIV_LO];
  wire [9:0] div_eff = (div_raw < `SLT_DIV_MIN) ? `SLT_DIV_MIN : div_raw;
  wire [10:0] hval   = htime_q[10:0];
  wire [1:0]  line_pulse_width    = htime_q[17:16];
  wire [1:0]  post_line_delay   = htime_q[19:18];
  wire [7:0]  lblank = htime_q[31:24];
  wire [9:0]  lval   = vtime_q[9:0];
  wire [7:0]  bias_line_count   = bias_q[7:0];

  // pixel clock edges: one bus-clock tick at end of each half period
  wire half_end  = (div_q == div_eff - 10'h001);
  wire pix_fall  = half_end & pixel_clock_out_o;   // a full pixel period ends
  wire last_line = (vcnt_q == lval);

  // register write, read one cycle later
  always @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      ctrl_q <= `SLT_CTRL_RST;
      htime_q <= `SLT_HTIME_RST;
      vtime_q <= `SLT_VTIME_RST;
      bias_q <= `SLT_BIAS_RST;
      base_q <= 22'h000000;
      reg_rdata_o <= 32'h0000_0000;
    end else begin
      if (reg_wr_i) begin
        case (reg_addr_i)
          `SLT_REG_CTRL:  ctrl_q <= reg_wdata_i;
          `SLT_REG_HTIME: htime_q <= reg_wdata_i;
          `SLT_REG_VTIME: vtime_q <= reg_wdata_i;
          `SLT_REG_BIAS:  bias_q <= reg_wdata_i;
          `SLT_REG_BASE:  base_q <= reg_wdata_i[23:2];
          default: ;
        endcase
      end
      reg_rdata_o <= 32'h0000_0000;                              // unmapped reads zero
      if (reg_rd_i) begin
        case (reg_addr_i)
          `SLT_REG_CTRL:   reg_rdata_o <= ctrl_q;
          `SLT_REG_HTIME:  reg_rdata_o <= htime_q;
          `SLT_REG_VTIME:  reg_rdata_o <= vtime_q;
          `SLT_REG_BIAS:   reg_rdata_o <= bias_q;
          `SLT_REG_BASE:   reg_rdata_o <= {8'h00, base_q, 2'h0};
          `SLT_REG_STATUS: reg_rdata_o <= {12'h000, vcnt_q, 3'h0, hcnt_q[4:0],
                                           ac_bias_toggle_o, frame_pulse_o};
          `SLT_REG_FIFO:   reg_rdata_o <= {19'h00000, busy_q, lo_cnt_q, 2'h0, up_cnt_q};
          default: reg_rdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // line sequencer: active pixels, line pulse, post delay, blanking
  always @(posedge ref_clk_i) begin
    if (!resetn_i || !en) begin
      st_q <= ST_ACTIVE;
      div_q <= 10'h000;
      hcnt_q <= 11'h000;
      vcnt_q <= 10'h000;
      wcnt_q <= 13'h0000;
      pixel_clock_out_o <= 1'b0;
      line_pulse_o <= 1'b0;
      frame_pulse_o <= 1'b0;
      frame_sync_irq_o <= 1'b0;
    end else begin
      frame_sync_irq_o <= 1'b0;
      frame_pulse_o <= (vcnt_q == 10'h000);
      case (st_q)
        ST_ACTIVE: begin
          div_q <= half_end ? 10'h000 : div_q + 10'h001;
          if (half_end)
            pixel_clock_out_o <= ~pixel_clock_out_o;
          if (pix_fall) begin
            if (hcnt_q == hval) begin
              hcnt_q <= 11'h000;
              st_q <= ST_PULSE;
              line_pulse_o <= 1'b1;
              wcnt_q <= (13'h0001 << (`SLT_WLH_BASE + line_pulse_width)) - 13'h0001;
            end else begin
              hcnt_q <= hcnt_q + 11'h001;
            end
          end
        end
        ST_PULSE: begin
          if (wcnt_q == 13'h0000) begin
            line_pulse_o <= 1'b0;
            st_q <= ST_DELAY;
            wcnt_q <= (13'h0001 << (`SLT_WLH_BASE + post_line_delay)) - 13'h0001;
          end else
            wcnt_q <= wcnt_q - 13'h0001;
        end
        ST_DELAY: begin
          if (wcnt_q == 13'h0000) begin
            st_q <= ST_BLANK;
            wcnt_q <= {2'h0, lblank, 3'h0};
          end else
            wcnt_q <= wcnt_q - 13'h0001;
        end
        ST_BLANK: begin
          if (wcnt_q == 13'h0000) begin
            st_q <= ST_ACTIVE;
            div_q <= 10'h000;
            if (last_line) begin
              vcnt_q <= 10'h000;
              frame_sync_irq_o <= 1'b1;
            end else
              vcnt_q <= vcnt_q + 10'h001;
          end else
            wcnt_q <= wcnt_q - 13'h0001;
        end
        default: st_q <= ST_ACTIVE;
      endcase
    end
  end

  // ac bias: per frame or per bias_line_count line pulses
  wire line_end = (st_q == ST_BLANK) && (wcnt_q == 13'h0000);
  always @(posedge ref_clk_i) begin
    if (!resetn_i || !en) begin
      ac_bias_toggle_o <= 1'b0;
      bcnt_q <= 8'h00;
    end else if (line_end) begin
      if (!bsel) begin
        if (last_line)
          ac_bias_toggle_o <= ~ac_bias_toggle_o;
      end else if (bcnt_q + 8'h01 >= bias_line_count) begin
        bcnt_q <= 8'h00;
        ac_bias_toggle_o <= ~ac_bias_toggle_o;
      end else
        bcnt_q <= bcnt_q + 8'h01;
    end
  end

  // burst dma: needs room for a whole burst; alternates halves for dual
  wire up_room  = (up_cnt_q <= `SLT_UPPER_DEPTH - `SLT_BURST_WORDS);
  wire lo_room  = (lo_cnt_q <= `SLT_LOWER_DEPTH - `SLT_BURST_WORDS);
  wire tgt_lo   = dual & side_q;
  assign mem_req_o  = en & ~busy_q & (tgt_lo ? lo_room : up_room);
  assign mem_addr_o = fetch_q;
  wire [31:0] swapped = ctrl_q[`SLT_CTRL_BIG] ?
    {mem_data_i[7:0], mem_data_i[15:8], mem_data_i[23:16], mem_data_i[31:24]} : mem_data_i;

  // shifter pulls words; one taken on a pixel clock rising edge once the last is shifted out
  wire pix_rise = (st_q == ST_ACTIVE) & half_end & ~pixel_clock_out_o;
  wire need     = pix_rise & (sh_left_q == 3'h0);
  wire up_pop   = need & (up_cnt_q != 5'h00);
  wire lo_pop   = need & dual & (lo_cnt_q != 5'h00);
  wire up_push  = busy_q & mem_valid_i & ~tgt_lo;
  wire lo_push  = busy_q & mem_valid_i & tgt_lo;

  always @(posedge ref_clk_i) begin
    if (!resetn_i || !en) begin
      busy_q <= 1'b0;
      beat_q <= 2'h0;
      side_q <= 1'b0;
      fetch_q <= base_q;
      up_cnt_q <= 5'h00;
      lo_cnt_q <= 5'h00;
      up_wr_q <= 4'h0;
      up_rd_q <= 4'h0;
      lo_wr_q <= 4'h0;
      lo_rd_q <= 4'h0;
      fifo_count_irq_o <= 1'b0;
    end else begin
      fifo_count_irq_o <= up_pop & (up_cnt_q == 5'h05);
      if (mem_req_o && mem_gnt_i)
        busy_q <= 1'b1;
      if (busy_q && mem_valid_i) begin
        fetch_q <= fetch_q + 22'h000001;
        beat_q <= beat_q + 2'h1;
        if (beat_q == 2'h3) begin
          busy_q <= 1'b0;
          side_q <= ~side_q;
        end
      end
      if (up_push) begin
        up_mem[up_wr_q] <= swapped;
        up_wr_q <= up_wr_q + 4'h1;
      end
      if (up_pop)
        up_rd_q <= up_rd_q + 4'h1;
      up_cnt_q <= up_cnt_q + {4'h0, up_push} - {4'h0, up_pop};
      if (lo_push) begin
        lo_mem[lo_wr_q] <= swapped;
        lo_wr_q <= (lo_wr_q == 4'hb) ? 4'h0 : lo_wr_q + 4'h1;
      end
      if (lo_pop)
        lo_rd_q <= (lo_rd_q == 4'hb) ? 4'h0 : lo_rd_q + 4'h1;
      lo_cnt_q <= lo_cnt_q + {4'h0, lo_push} - {4'h0, lo_pop};
    end
  end

  // mono serialiser: 4 or 8 bits per pixel clock, dual puts lower on high nibble
  always @(posedge ref_clk_i) begin
    if (!resetn_i || !en) begin
      sh_q <= 32'h0000_0000;
      sh_left_q <= 3'h0;
      pixel_data_bus_o <= 8'h00;
    end else if (pix_rise) begin
      if (up_pop) begin
        if (dual) begin
          sh_q <= {up_mem[up_rd_q][31:16], lo_pop ? lo_mem[lo_rd_q][31:16] : 16'h0000};
          pixel_data_bus_o <= {lo_pop ? lo_mem[lo_rd_q][31:28] : 4'h0,
                               up_mem[up_rd_q][31:28]};
          sh_left_q <= 3'h3;
        end else if (wide) begin
          sh_q <= {up_mem[up_rd_q][23:0], 8'h00};
          pixel_data_bus_o <= up_mem[up_rd_q][31:24];
          sh_left_q <= 3'h3;
        end else begin
          sh_q <= {up_mem[up_rd_q][27:0], 4'h0};
          pixel_data_bus_o <= {4'h0, up_mem[up_rd_q][31:28]};
          sh_left_q <= 3'h7;
        end
      end else if (sh_left_q != 3'h0) begin
        sh_left_q <= sh_left_q - 3'h1;
        if (dual) begin
          pixel_data_bus_o <= {sh_q[15:12], sh_q[31:28]};
          sh_q <= {sh_q[27:16], 4'h0, sh_q[11:0], 4'h0};
        end else if (wide) begin
          pixel_data_bus_o <= sh_q[31:24];
          sh_q <= {sh_q[23:0], 8'h00};
        end else begin
          pixel_data_bus_o <= {4'h0, sh_q[31:28]};
          sh_q <= {sh_q[27:0], 4'h0};
        end
      end
    end
  end

endmodule // slt_stn_timing

`default_nettype wire

// ==== testbench/slt_mem_model.sv ====
/* slt_mem_model.sv: system memory seen by the display fetch.
   assumes: grant sampled with request, four beats per burst. */
`timescale 1ns/10ps
`default_nettype none
module slt_mem_model (
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic        req_i,
  input  wire logic [21:0] addr_i,
  input  wire logic        slow_i,
  output logic             gnt_o,
  output logic             valid_o,
  output logic [31:0]      data_o
);
  logic [2:0]  left_q;
  logic [21:0] ptr_q;
  logic        ph_q;
  // slow mode skips every other cycle; idle data lines keep changing
  always @(posedge clk_i) begin
    ph_q    <= resetn_i & ~ph_q;
    valid_o <= 1'b0;
    data_o  <= ~data_o;
    if (!resetn_i) begin
      gnt_o  <= 1'b0;
      left_q <= 3'h0;
      data_o <= 32'h0;
    end else if (gnt_o && req_i) begin
      gnt_o  <= 1'b0;
      left_q <= 3'h4;
      ptr_q  <= addr_i;
    end else if (left_q != 3'h0) begin
      if (!slow_i || ph_q) begin
        valid_o <= 1'b1;
        data_o  <= {~ptr_q[9:0], ptr_q};
        ptr_q   <= ptr_q + 22'h1;
        left_q  <= left_q - 3'h1;
      end
    end else begin
      gnt_o <= req_i & ~(slow_i & ph_q);
    end
  end
endmodule // slt_mem_model
`default_nettype wire

// ==== testbench/slt_stn_props.sv ====
/* slt_stn_props.sv: port checks of the stn timing block.
   assumes: bound into slt_stn_timing; one clock, sync low reset. */
`timescale 1ns/10ps
`default_nettype none
module slt_stn_props (
  input wire logic        ref_clk_i,
  input wire logic        resetn_i,
  input wire logic        reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic        mem_req_o,
  input wire logic        mem_gnt_i,
  input wire logic        mem_valid_i,
  input wire logic        frame_pulse_o,
  input wire logic        line_pulse_o,
  input wire logic        pixel_clock_out_o,
  input wire logic        frame_sync_irq_o
);
  logic       busy_q;
  logic [1:0] beat_q;
  // burst tracker: the body is hidden, so the four beats are counted here
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i || (mem_req_o && mem_gnt_i)) begin
      busy_q <= resetn_i;
      beat_q <= 2'h0;
    end else if (busy_q && mem_valid_i) begin
      busy_q <= (beat_q != 2'h3);
      beat_q <= beat_q + 2'h1;
    end
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  sequence grant_s;
    mem_req_o && mem_gnt_i;
  endsequence
  sequence pclk_up_s;
    $rose(pixel_clock_out_o);
  endsequence
  rd_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
    else $error("read data not idle");
  req_drop_a: assert property (grant_s |=> !mem_req_o)
    else $error("request kept after grant");
  burst_hold_a: assert property (busy_q |-> !mem_req_o)
    else $error("request inside a burst");
  pclk_high_a: assert property (pclk_up_s |=> pixel_clock_out_o)
    else $error("pixel clock high phase short");
  pclk_line_a: assert property (line_pulse_o |=> $stable(pixel_clock_out_o))
    else $error("pixel clock moves in line pulse");
  frame_hold_a: assert property ($rose(frame_pulse_o) |=> frame_pulse_o [*8])
    else $error("frame pulse short");
  line_width_a: assert property ($rose(line_pulse_o) |=> line_pulse_o [*8])
    else $error("line pulse short");
  fsync_pulse_a: assert property (frame_sync_irq_o |=> !frame_sync_irq_o)
    else $error("frame event not a pulse");
endmodule // slt_stn_props
bind slt_stn_timing slt_stn_props u_props (.ref_clk_i, .resetn_i, .reg_rd_i, .reg_rdata_o,
  .mem_req_o, .mem_gnt_i, .mem_valid_i, .frame_pulse_o, .line_pulse_o, .pixel_clock_out_o,
  .frame_sync_irq_o);
`default_nettype wire

// ==== testbench/test_slt_stn_timing.sv ====
/* test_slt_stn_timing.sv: self-checking bench of the stn timing block.
   assumes: design, memory model and checker compiled before it. */
`include "slt_consts.vh"
`timescale 1ns/10ps
`default_nettype none
module test_slt_stn_timing;
  logic        ref_clk_i, resetn_i, reg_wr_i, reg_rd_i, slow, got_first, mem_gnt_i;
  logic        mem_req_o, mem_valid_i, frame_pulse_o, line_pulse_o, pixel_clock_out_o;
  logic        ac_bias_toggle_o, frame_sync_irq_o, fifo_count_irq_o;
  logic [3:0]  up4;
  logic [7:0]  reg_addr_i, pixel_data_bus_o;
  logic [21:0] mem_addr_o, first_addr;
  logic [31:0] reg_wdata_i, reg_rdata_o, mem_data_i, rd, seed;
  logic [31:0] rst_tab [4] = '{`SLT_CTRL_RST, `SLT_HTIME_RST, `SLT_VTIME_RST, `SLT_BIAS_RST};
  int          err_total, checks_done, n, pm, lines, flips, irqs, hi, h, v, d, m, wl, wd, bl;
  slt_stn_timing dut_u (.ref_clk_i, .resetn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
    .reg_rd_i, .reg_rdata_o, .mem_req_o, .mem_addr_o, .mem_gnt_i, .mem_valid_i, .mem_data_i,
    .frame_pulse_o, .line_pulse_o, .pixel_clock_out_o, .ac_bias_toggle_o, .pixel_data_bus_o,
    .frame_sync_irq_o, .fifo_count_irq_o);
  slt_mem_model mem_u (.clk_i(ref_clk_i), .resetn_i, .req_i(mem_req_o), .addr_i(mem_addr_o),
    .slow_i(slow), .gnt_o(mem_gnt_i), .valid_o(mem_valid_i), .data_o(mem_data_i));
  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end
  // first fetch address after each reset
  always @(posedge ref_clk_i) begin
    got_first <= resetn_i & (got_first | (mem_req_o & mem_gnt_i));
    if (!got_first && mem_req_o && mem_gnt_i) first_addr <= mem_addr_o;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic sig(input int s);
    return s == 0 ? line_pulse_o : s == 1 ? pixel_clock_out_o :
      s == 2 ? frame_pulse_o : ac_bias_toggle_o;
  endfunction
  // bus clocks of one line with the clamped divisor
  function automatic int line_len();
    return (h + 1) * 2 * d + (16 << wl) + (16 << wd) + 8 * bl;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] x);
    @(posedge ref_clk_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= x;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a);
    @(posedge ref_clk_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    @(negedge ref_clk_i);
    rd = reg_rdata_o;
  endtask
  task automatic pulse_reset();
    @(posedge ref_clk_i);
    resetn_i <= 1'b0;
    @(posedge ref_clk_i);
    resetn_i <= 1'b1;
  endtask
  // waits for two events of one output, counting what passes between them
  task automatic span(input int s);
    int   e = 0;
    int   k = 0;
    logic p = sig(s);
    logic lp = line_pulse_o;
    logic bp = ac_bias_toggle_o;
    logic q;
    {n, lines, flips, irqs, hi} = 160'h0;
    up4 = 4'h0;
    while (e < 2 && k < 50000) begin
      @(negedge ref_clk_i);
      q = sig(s);
      if (e == 1) begin
        n++;
        lines += line_pulse_o & !lp;
        flips += ac_bias_toggle_o != bp;
        irqs += frame_sync_irq_o;
        hi += frame_pulse_o;
        up4 |= pixel_data_bus_o[7:4];
      end
      e += (s == 3) ? q != p : q & !p;
      {p, lp, bp, k} = {q, line_pulse_o, ac_bias_toggle_o, k + 1};
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // watchdog: the whole run needs far fewer cycles than this
  initial begin
    repeat (100000) @(posedge ref_clk_i);
    err_total++;
    end_of_test();
  end
  initial begin
    {resetn_i, reg_wr_i, reg_rd_i, slow} = 4'h0;
    {reg_addr_i, reg_wdata_i} = 40'h0;
    seed = 32'hb2d2;
    repeat (3) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    foreach (rst_tab[i]) begin
      rd_reg(8'(i * 4));
      chk(rd, rst_tab[i]);
    end
    wr(8'h1c, 32'hffff_ffff);
    rd_reg(8'h1c);
    chk(rd, 32'h0);
    $display("register test done");
    // one panel type per pass; the first pass asks for a divisor below two
    for (int t = 0; t < 3; t++) begin
      pulse_reset();
      h = 3 + rnd() % 8;
      v = 1 + rnd() % 3;
      d = t == 0 ? 1 : rnd() % 6;
      m = 1 + rnd() % 4;
      wl = rnd() % 2;
      wd = rnd() % 2;
      bl = rnd() % 4;
      slow <= rnd() % 2;
      wr(8'h04, bl << 24 | wd << 18 | wl << 16 | h);
      rd_reg(8'h04);
      chk(rd, bl << 24 | wd << 18 | wl << 16 | h);
      wr(8'h08, v);
      wr(8'h0c, m);
      wr(8'h00, d << 8 | t << 2 | t % 2 << 1 | 1);
      if (d < 2) d = 2;
      span(1);
      pm = n;
      span(1);
      chk(n < pm ? n : pm, 2 * d);
      span(0);
      chk(n >= line_len() && n <= line_len() + 4, 1);
      span(2);
      chk(lines, v + 1);
      chk(irqs, 1);
      chk(hi >= line_len() && hi <= line_len() + 4, 1);
      chk(up4 != 0, t != 1);
      if (t % 2 == 0) chk(flips, 1);
      else span(3);
      if (t % 2 == 1) chk(lines, m);
      $display("timing test %0d done", t);
    end
    // slowest pixel clock lets the fifos fill; base sits near the top of memory
    for (int pt = 0; pt < 3; pt += 2) begin
      pulse_reset();
      wr(8'h10, 32'h00ff_fff0);
      wr(8'h00, 32'h0003_ff01 | pt << 2);
      repeat (400) @(posedge ref_clk_i);
      rd_reg(8'h18);
      chk(rd[4:0] > 12 && rd[4:0] < 17, 1);
      chk(rd[11:7] > 8 && rd[11:7] < 13, pt == 0);
      chk(pt == 0 || rd[11:7] == 0, 1);
      chk(first_addr, 22'h3f_fffc);
      $display("fifo test %0d done", pt);
    end
    end_of_test();
  end
endmodule // test_slt_stn_timing
`default_nettype wire
